//--- rtl/psc_chan.sv
// one pwm channel: offset and delay shift, pulse limit clamp, 50% ramp and off
`timescale 1ns/1ps
module psc_chan (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       mod_en,      // modulator clock enable
  input  wire logic [7:0] phase,       // shared frame counter
  input  wire logic [7:0] duty,        // requested high time
  input  wire logic [2:0] limit_code,  // pulse limit code
  input  wire logic [5:0] delay,       // signed delay, units of four clocks
  input  wire logic [7:0] offset,      // global offset
  input  wire logic       active,      // channel modulating
  input  wire logic       ramping,     // channel in 50% period
  output logic            pwm_q        // registered pwm level
);

  wire logic [7:0] minw;       // shortest allowed pulse
  wire logic [7:0] maxw;       // longest allowed pulse
  wire logic [7:0] duty_lim;   // clamped duty
  wire logic [7:0] shift;      // total edge shift, wraps in frame
  wire logic [7:0] local_ph;   // phase seen by this channel
  wire logic       level_nxt;  // next pwm level

  assign minw     = psc_pkg::min_width(limit_code);
  assign maxw     = 8'(9'h100 - {1'b0, minw});
  assign duty_lim = (duty < minw) ? minw : ((duty > maxw) ? maxw : duty);
  // signed delay times four wraps mod 256, same as shifting the edge
  assign shift    = offset + {delay, 2'b00};
  assign local_ph = phase - shift;
  // ramp wins over modulation so a start with a soft period never jumps straight to audio
  assign level_nxt = ramping ? (local_ph < psc_pkg::HALF_DUTY) :
                     (active ? (local_ph < duty_lim) : 1'b0);

  // output flop, updated on modulator clocks only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwm_q <= 1'b0;
    end else if (mod_en) begin
      pwm_q <= level_nxt;
    end
  end

  a_off_low: assert property (@(posedge clk) disable iff (rst)
    (mod_en && !active && !ramping) |=> !pwm_q) else $error("idle channel drives high");
  a_ramp_high: assert property (@(posedge clk) disable iff (rst)
    (mod_en && ramping && local_ph == 8'h00) |=> pwm_q) else $error("ramp not high at frame start");
  a_ramp_low: assert property (@(posedge clk) disable iff (rst)
    (mod_en && ramping && local_ph == psc_pkg::HALF_DUTY) |=> !pwm_q) else $error("ramp not half duty");
  a_min_width: assert property (@(posedge clk) disable iff (rst)
    (mod_en && active && !ramping && local_ph < minw) |=> pwm_q) else $error("pulse shorter than limit");

endmodule // psc_chan

//--- rtl/psc_pkg.sv
// constants, types and helper functions of the pwm output stage configuration block
package psc_pkg;

  // clock and time units
  localparam int CLK_FREQ_HZ      = 10_000_000;           // system clock rate
  localparam int TENTH_MS_PER_SEC = 10_000;               // ramp table unit is 0.1 ms
  localparam int CYC_PER_TENTH_MS = CLK_FREQ_HZ / TENTH_MS_PER_SEC;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_SYS_CTRL    = 6'h05;
  localparam logic [5:0] IDX_PULSE_LIMIT = 6'h10;
  localparam logic [5:0] IDX_CHAN1_DELAY = 6'h11;
  localparam logic [5:0] IDX_CHAN6_DELAY = 6'h16;
  localparam logic [5:0] IDX_OFFSET      = 6'h17;
  localparam logic [5:0] IDX_OFF_GROUP   = 6'h19;
  localparam logic [5:0] IDX_RAMP        = 6'h1a;
  localparam logic [5:0] IDX_STATUS      = 6'h1f;

  // channel count and field layout
  localparam int NUM_CHAN          = 6;
  localparam int SYS_SHUTDOWN_BIT  = 6;
  localparam int SYS_ALLCH_BIT     = 5;
  localparam int STAGE_SE_BIT      = 7;
  localparam int STATUS_BUSY_BIT   = 7;
  localparam logic [7:0] GROUP_MASK = 8'h3f;
  localparam logic [7:0] DELAY_MASK = 8'hfc;
  localparam logic [7:0] LIMIT_MASK = 8'h07;
  localparam logic [7:0] RAMP_MASK  = 8'h9f;

  // reset values
  localparam logic [7:0]  RST_SYS_CTRL    = 8'h40;
  localparam logic [7:0]  RST_PULSE_LIMIT = 8'h00;
  localparam logic [47:0] RST_DELAY_ALL   = {8'h00, 8'h00, 8'h00, 8'h1c, 8'h34, 8'h4c};
  localparam logic [7:0]  RST_OFFSET      = 8'h00;
  localparam logic [7:0]  RST_OFF_GROUP   = 8'h30;
  localparam logic [7:0]  RST_RAMP        = 8'h00;

  // pwm frame is 256 modulator clocks, half of it for 50% duty
  localparam int         PHASE_W   = 8;
  localparam logic [7:0] HALF_DUTY = 8'h80;

  // sequencer states, gray along idle -> ramp -> idle
  typedef enum logic [1:0] {
    PSC_IDLE = 2'b00,
    PSC_RAMP = 2'b01
  } psc_seq_t;

  // minimum pulse width for a limit code, 2(n+1) modulator clocks
  function automatic logic [7:0] min_width(input logic [2:0] code);
    min_width = {4'h0, ({1'b0, code} + 4'h1)} << 1;
  endfunction

  // ramp length in tenths of a millisecond
  function automatic logic [17:0] ramp_tenths(input logic [4:0] code);
    case (code)
      5'h08:   ramp_tenths = 18'd165;
      5'h09:   ramp_tenths = 18'd239;
      5'h0a:   ramp_tenths = 18'd314;
      5'h0b:   ramp_tenths = 18'd404;
      5'h0c:   ramp_tenths = 18'd539;
      5'h0d:   ramp_tenths = 18'd703;
      5'h0e:   ramp_tenths = 18'd942;
      5'h0f:   ramp_tenths = 18'd1257;
      5'h10:   ramp_tenths = 18'd1646;
      5'h11:   ramp_tenths = 18'd2394;
      5'h12:   ramp_tenths = 18'd3142;
      5'h13:   ramp_tenths = 18'd4039;
      5'h14:   ramp_tenths = 18'd5386;
      5'h15:   ramp_tenths = 18'd7031;
      5'h16:   ramp_tenths = 18'd9425;
      5'h17:   ramp_tenths = 18'd12566;
      5'h18:   ramp_tenths = 18'd17281;
      5'h19:   ramp_tenths = 18'd25136;
      5'h1a:   ramp_tenths = 18'd32991;
      5'h1b:   ramp_tenths = 18'd42417;
      5'h1c:   ramp_tenths = 18'd56556;
      5'h1d:   ramp_tenths = 18'd73837;
      5'h1e:   ramp_tenths = 18'd98973;
      5'h1f:   ramp_tenths = 18'd131964;
      default: ramp_tenths = 18'd0;
    endcase
  endfunction

endpackage

//--- rtl/psc_top.sv
// apb register file, start/stop sequencer and six pwm channels
`timescale 1ns/1ps
module psc_top #(
  parameter int MOD_DIV       = 1,                          // system clocks per modulator clock
  parameter int RAMP_UNIT_CYC = psc_pkg::CYC_PER_TENTH_MS   // clocks per 0.1 ms of ramp
) (
  input  wire logic        SYS_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [47:0] CH_DUTY,
  output logic [5:0]       PWM_OUT,
  output logic             STAGE_SE
);

  // register storage
  logic [7:0]  sys_ctrl_r;    // shutdown and all-channels bits
  logic [7:0]  limit_r;       // pulse limit code
  logic [47:0] delay_r;       // six delay registers, channel 1 lowest
  logic [7:0]  offset_r;      // global offset
  logic [7:0]  group_r;       // channel off group
  logic [7:0]  ramp_r;        // ramp code and stage select

  // apb state
  logic [31:0] rdata_r;       // read data latched in setup
  logic        err_r;         // error answer latched in setup

  // sequencer state
  psc_pkg::psc_seq_t seq_r;   // idle or ramping
  psc_pkg::psc_seq_t seq_nxt; // next sequencer state
  logic [5:0]  act_r;         // channels modulating
  logic [5:0]  act_nxt;
  logic [5:0]  tgt_r;         // channel set after the ramp
  logic [5:0]  tgt_nxt;
  logic [5:0]  rmask_r;       // channels in 50% period
  logic [5:0]  rmask_nxt;
  logic [31:0] timer_r;       // ramp cycle counter
  logic [31:0] timer_nxt;
  logic [31:0] len_r;         // ramp length latched at start
  logic [31:0] len_nxt;

  // modulator clock divider and frame counter
  logic [15:0] div_r;         // divider count
  logic        mod_en;        // one-cycle modulator tick
  logic [7:0]  phase_r;       // frame counter
  logic        stage_r;       // registered stage select

  // apb decode
  wire logic [5:0]  idx;        // word index of access
  wire logic        aligned;    // low address bits zero
  wire logic        hit_delay;  // index lands on a delay register
  wire logic [2:0]  dch;        // delay channel number
  wire logic        mapped;     // address decodes to a register
  wire logic        setup;      // setup phase of a transfer
  wire logic        access_wr;  // write takes effect this edge
  wire logic [7:0]  wbyte;      // low write byte
  wire logic [7:0]  rd_byte;    // read mux output

  assign idx       = PADDR[7:2];
  assign aligned   = (PADDR[1:0] == 2'b00);
  assign hit_delay = (idx >= psc_pkg::IDX_CHAN1_DELAY) && (idx <= psc_pkg::IDX_CHAN6_DELAY);
  assign dch       = 3'(idx - psc_pkg::IDX_CHAN1_DELAY);
  assign mapped    = aligned && (hit_delay || idx == psc_pkg::IDX_SYS_CTRL ||
                     idx == psc_pkg::IDX_PULSE_LIMIT || idx == psc_pkg::IDX_OFFSET ||
                     idx == psc_pkg::IDX_OFF_GROUP || idx == psc_pkg::IDX_RAMP ||
                     idx == psc_pkg::IDX_STATUS);
  assign setup     = PSEL && !PENABLE;
  assign access_wr = PSEL && PENABLE && PWRITE && mapped;
  assign wbyte     = PWDATA[7:0];

  // read mux; status shows live sequencer state
  assign rd_byte = !aligned ? 8'h00 :
                   hit_delay ? delay_r[dch*8 +: 8] :
                   (idx == psc_pkg::IDX_SYS_CTRL)    ? sys_ctrl_r :
                   (idx == psc_pkg::IDX_PULSE_LIMIT) ? limit_r :
                   (idx == psc_pkg::IDX_OFFSET)      ? offset_r :
                   (idx == psc_pkg::IDX_OFF_GROUP)   ? group_r :
                   (idx == psc_pkg::IDX_RAMP)        ? ramp_r :
                   (idx == psc_pkg::IDX_STATUS)      ? {(seq_r == psc_pkg::PSC_RAMP), 1'b0, act_r} :
                   8'h00;

  // zero wait state: access phase always completes
  assign PREADY  = PSEL && PENABLE;
  assign PRDATA  = rdata_r;
  assign PSLVERR = err_r && PSEL && PENABLE;

  // read data and error latched during setup so outputs come from flops
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rdata_r <= 32'h0000_0000;
      err_r   <= 1'b0;
    end else if (setup) begin
      rdata_r <= {24'h00_0000, rd_byte};
      err_r   <= !mapped;
    end
  end

  // control registers; reserved bits forced to zero on write, except in the system control register
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sys_ctrl_r <= psc_pkg::RST_SYS_CTRL;
      limit_r    <= psc_pkg::RST_PULSE_LIMIT;
      delay_r    <= psc_pkg::RST_DELAY_ALL;
      offset_r   <= psc_pkg::RST_OFFSET;
      group_r    <= psc_pkg::RST_OFF_GROUP;
      ramp_r     <= psc_pkg::RST_RAMP;
    end else if (access_wr) begin
      if (idx == psc_pkg::IDX_SYS_CTRL) sys_ctrl_r <= wbyte;
      if (idx == psc_pkg::IDX_PULSE_LIMIT) limit_r <= wbyte & psc_pkg::LIMIT_MASK;
      if (hit_delay) delay_r[dch*8 +: 8] <= wbyte & psc_pkg::DELAY_MASK;
      if (idx == psc_pkg::IDX_OFFSET) offset_r <= wbyte;
      if (idx == psc_pkg::IDX_OFF_GROUP) group_r <= wbyte & psc_pkg::GROUP_MASK;
      if (idx == psc_pkg::IDX_RAMP) ramp_r <= wbyte & psc_pkg::RAMP_MASK;
    end
  end

  // modulator clock divider; every limit, delay and offset count uses this tick
  assign mod_en = (div_r == 16'(MOD_DIV - 1));

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      div_r   <= 16'h0000;
      phase_r <= 8'h00;
    end else if (mod_en) begin
      div_r   <= 16'h0000;
      phase_r <= phase_r + 8'h01;
    end else begin
      div_r   <= div_r + 16'h0001;
    end
  end

  // stage select follows the register
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      stage_r <= 1'b0;
    end else begin
      stage_r <= ramp_r[psc_pkg::STAGE_SE_BIT];
    end
  end
  assign STAGE_SE = stage_r;

  // wanted channel set from shutdown, all-channels and group bits
  wire logic       shutdown;   // outputs held off
  wire logic       allch;      // every channel runs unless shutdown is set
  wire logic [5:0] want;       // channels that should modulate
  wire logic [31:0] ramp_len;  // ramp length for current code

  assign shutdown = sys_ctrl_r[psc_pkg::SYS_SHUTDOWN_BIT];
  assign allch    = sys_ctrl_r[psc_pkg::SYS_ALLCH_BIT];
  assign want     = shutdown ? 6'h00 :
                    (allch ? 6'h3f : ~group_r[5:0]);
  // codes with both upper bits low decode to zero length
  assign ramp_len = 32'(psc_pkg::ramp_tenths(ramp_r[4:0])) * 32'(RAMP_UNIT_CYC);

  // sequencer: with a nonzero ramp length, a change of wanted set passes through one 50% period
  always_comb begin
    seq_nxt   = seq_r;
    act_nxt   = act_r;
    tgt_nxt   = tgt_r;
    rmask_nxt = rmask_r;
    timer_nxt = timer_r;
    len_nxt   = len_r;
    case (seq_r)
      psc_pkg::PSC_IDLE: begin
        if (want != act_r) begin
          if (ramp_len == 32'h0000_0000) begin
            // no soft period: switch straight over
            act_nxt = want;
          end else begin
            // both starting and stopping channels get the 50% period
            tgt_nxt   = want;
            rmask_nxt = want ^ act_r;
            act_nxt   = act_r & want;
            timer_nxt = 32'h0000_0000;
            len_nxt   = ramp_len;
            seq_nxt   = psc_pkg::PSC_RAMP;
          end
        end
      end
      psc_pkg::PSC_RAMP: begin
        // length held for the whole ramp, later code writes wait
        if (timer_r >= len_r - 32'h0000_0001) begin
          act_nxt   = tgt_r;
          rmask_nxt = 6'h00;
          seq_nxt   = psc_pkg::PSC_IDLE;
        end else begin
          timer_nxt = timer_r + 32'h0000_0001;
        end
      end
      default: begin
        seq_nxt   = psc_pkg::PSC_IDLE;
        rmask_nxt = 6'h00;
      end
    endcase
  end

  // sequencer flops, everything off after reset
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      seq_r   <= psc_pkg::PSC_IDLE;
      act_r   <= 6'h00;
      tgt_r   <= 6'h00;
      rmask_r <= 6'h00;
      timer_r <= 32'h0000_0000;
      len_r   <= 32'h0000_0000;
    end else begin
      seq_r   <= seq_nxt;
      act_r   <= act_nxt;
      tgt_r   <= tgt_nxt;
      rmask_r <= rmask_nxt;
      timer_r <= timer_nxt;
      len_r   <= len_nxt;
    end
  end

  // six channel instances
  genvar gi;
  generate
    for (gi = 0; gi < psc_pkg::NUM_CHAN; gi++) begin : g_chan
      psc_chan i_psc_chan (
        .clk        (SYS_CLK),
        .rst        (SYS_RST),
        .mod_en     (mod_en),
        .phase      (phase_r),
        .duty       (CH_DUTY[gi*8 +: 8]),
        .limit_code (limit_r[2:0]),
        .delay      (delay_r[gi*8+2 +: 6]),
        .offset     (offset_r),
        .active     (act_r[gi]),
        .ramping    (rmask_r[gi]),
        .pwm_q      (PWM_OUT[gi])
      );
    end
  endgenerate

  a_ramp_bound: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (seq_r == psc_pkg::PSC_RAMP) |-> (timer_r < len_r)) else $error("ramp counter past length");
  a_ramp_end: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (seq_r == psc_pkg::PSC_RAMP && timer_r == len_r - 32'h0000_0001)
    |=> (seq_r == psc_pkg::PSC_IDLE && act_r == $past(tgt_r) && rmask_r == 6'h00))
    else $error("ramp did not finish on time");
  a_no_ramp: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (seq_r == psc_pkg::PSC_IDLE && want != act_r && ramp_r[4:3] == 2'b00)
    |=> (act_r == $past(want) && rmask_r == 6'h00)) else $error("zero code still ramped");
  a_ramp_start: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (seq_r == psc_pkg::PSC_IDLE && want != act_r && ramp_r[4:3] != 2'b00)
    |=> (rmask_r == ($past(want) ^ $past(act_r)) && seq_r == psc_pkg::PSC_RAMP))
    else $error("wrong channels in soft period");
  a_shut_off: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (shutdown && seq_r == psc_pkg::PSC_IDLE && act_r == 6'h00) |=> (act_r == 6'h00))
    else $error("channel started while shut down");
  a_offset_write: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (access_wr && idx == psc_pkg::IDX_OFFSET) |=> (offset_r == $past(PWDATA[7:0])))
    else $error("offset write lost");
  a_delay_read: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (setup && hit_delay && aligned) |=> (PRDATA[1:0] == 2'b00 && PRDATA[31:8] == 24'h00_0000))
    else $error("delay unused bits not zero");
  a_group_rsvd: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (access_wr && idx == psc_pkg::IDX_OFF_GROUP) |=> (group_r[7:6] == 2'b00 &&
    group_r[5:0] == $past(PWDATA[5:0]))) else $error("group mask write wrong");

endmodule // psc_top

//--- tb/psc_stage_model.sv
// external power stage model: high-time counts and edge positions per pwm channel
`timescale 1ns/1ps
module psc_stage_model (
  input  wire logic            clk,      // system clock
  input  wire logic            rst,      // async reset, active high
  input  wire logic [5:0]      pwm,      // switching nodes from the block
  input  wire logic            meas,     // measure window open
  output logic      [5:0][8:0] hi_cnt,   // high clocks per channel in window
  output logic      [5:0][7:0] rise_at   // frame position of last rising edge
);
  logic [7:0] pos_r;  // free-running frame position, 256 clocks
  logic [5:0] pwm_r;  // previous levels for edge detection

  // the stage only listens; it has no handshake, so it can neither stall nor answer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pos_r   <= 8'h00;
      pwm_r   <= 6'h00;
      hi_cnt  <= '0;
      rise_at <= '0;
    end else begin
      pos_r <= pos_r + 8'h01;
      pwm_r <= pwm;
      for (int i = 0; i < 6; i++) begin
        // window closed clears, so each window starts from zero
        hi_cnt[i] <= meas ? hi_cnt[i] + {8'h00, pwm[i]} : 9'h000;
        // only differences between channels mean anything: pos_r is unaligned
        if (pwm[i] && !pwm_r[i]) begin
          rise_at[i] <= pos_r;
        end
      end
    end
  end
endmodule // psc_stage_model

//--- tb/pwm_output_stage_config_tb.sv
// self-checking bench of the pwm output stage configuration block
`timescale 1ns/1ps
module pwm_output_stage_config_tb;
  logic            clk;          // 10 MHz system clock
  logic            rst;          // async reset, active high
  logic            psel;         // apb select
  logic            penable;      // apb access phase
  logic            pwrite;       // apb direction
  logic [7:0]      paddr;        // apb byte address
  logic [31:0]     pwdata;       // apb write data
  logic [31:0]     prdata;       // apb read data
  logic            pready;       // apb ready
  logic            pslverr;      // apb error
  logic [47:0]     ch_duty;      // requested high time per channel
  logic [5:0]      pwm_out;      // pwm levels
  logic            stage_se;     // output stage select
  logic            meas;         // model window
  logic [5:0][8:0] hi_cnt;       // model high counts
  logic [5:0][7:0] rise_at;      // model edge positions
  logic [5:0][8:0] hi;           // snapshot of high counts
  logic [5:0][7:0] r;            // snapshot of edge positions
  logic [7:0]      r_ref;        // channel 4 edge before offset change
  logic [31:0]     rd;           // last read data
  logic            er;           // last error flag
  int              n_errors;     // mismatches
  int              checks_done;  // comparisons made

  // ramp unit of one clock keeps soft periods short in simulation
  psc_top #(.MOD_DIV(1), .RAMP_UNIT_CYC(1)) i_psc_top (
    .SYS_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CH_DUTY(ch_duty), .PWM_OUT(pwm_out), .STAGE_SE(stage_se));
  psc_stage_model i_psc_stage_model (
    .clk(clk), .rst(rst), .pwm(pwm_out), .meas(meas), .hi_cnt(hi_cnt), .rise_at(rise_at));

  // free-running clock, 100 ns period
  always #50 clk = ~clk;

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // high counts of all six channels, channel 1 in the low nine bits
  task automatic chk_hi(input logic [53:0] exp);
    for (int i = 0; i < 6; i++) begin
      checks_done++;
      if (hi[i] !== exp[9*i +: 9]) begin
        n_errors++;
        $display("Error high clocks ch%0d expected %0d seen %0d", i + 1, exp[9*i +: 9], hi[i]);
      end
    end
  endtask

  // one apb transfer; request held until pready is sampled high or 16 more clocks pass
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 16) begin
      chk("apb ready", 32'h1, 32'h0);
    end
  endtask

  task automatic rdchk(input string name, input logic [5:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(name, {24'h000000, exp}, rd);
  endtask

  // one full 256-clock frame of observation
  task automatic measure();
    @(posedge clk);
    meas <= 1'b1;
    repeat (256) @(posedge clk);
    meas <= 1'b0;
    #1;
    hi = hi_cnt;
  endtask

  task automatic t_reset_values();
    rdchk("sys_ctrl", psc_pkg::IDX_SYS_CTRL, 8'h40);
    rdchk("pulse_limit", psc_pkg::IDX_PULSE_LIMIT, 8'h00);
    rdchk("chan1_edge_delay", 6'h11, {6'd19, 2'b00});
    rdchk("chan2_edge_delay", 6'h12, {6'd13, 2'b00});
    rdchk("chan3_edge_delay", 6'h13, {6'd7, 2'b00});
    rdchk("chan6_edge_delay", 6'h16, 8'h00);
    rdchk("pwm_global_offset", psc_pkg::IDX_OFFSET, 8'h00);
    rdchk("channel_off_group", psc_pkg::IDX_OFF_GROUP, 8'h30);
    measure();
    chk_hi(54'h0);
  endtask

  task automatic t_group_start();
    apb(1'b1, psc_pkg::IDX_SYS_CTRL, 8'h00);
    rdchk("active set", psc_pkg::IDX_STATUS, {2'b00, ~6'h30});
    measure();
    chk_hi({9'd0, 9'd0, {4{9'd64}}});
  endtask

  task automatic t_shutdown();
    apb(1'b1, psc_pkg::IDX_RAMP, 8'h07);
    apb(1'b1, psc_pkg::IDX_OFF_GROUP, 8'h00);
    apb(1'b1, psc_pkg::IDX_SYS_CTRL, 8'h40);
    rdchk("stop without ramp", psc_pkg::IDX_STATUS, 8'h00);
    measure();
    chk_hi(54'h0);
  endtask

  // code 0x0a gives 314 units, long enough to hold a whole frame inside
  task automatic t_soft_ramp();
    apb(1'b1, psc_pkg::IDX_RAMP, 8'h0a);
    apb(1'b1, psc_pkg::IDX_SYS_CTRL, 8'h20);
    rdchk("ramp busy", psc_pkg::IDX_STATUS, 8'h80);
    measure();
    chk_hi({6{9'd128}});
    repeat (80) @(posedge clk);
    rdchk("all started", psc_pkg::IDX_STATUS, 8'h3f);
  endtask

  task automatic t_edges();
    apb(1'b1, 6'h15, 8'hfc);
    apb(1'b1, 6'h16, {6'd31, 2'b00});
    repeat (300) @(posedge clk);
    r = rise_at;
    chk("ch1 shift", {24'h0, 8'(19 * 4)}, {24'h0, 8'(r[0] - r[3])});
    chk("ch2 shift", {24'h0, 8'(13 * 4)}, {24'h0, 8'(r[1] - r[3])});
    chk("ch3 shift", {24'h0, 8'(7 * 4)}, {24'h0, 8'(r[2] - r[3])});
    chk("ch5 shift", {24'h0, 8'(-1 * 4)}, {24'h0, 8'(r[4] - r[3])});
    chk("ch6 shift", {24'h0, 8'(31 * 4)}, {24'h0, 8'(r[5] - r[3])});
    r_ref = r[3];
    apb(1'b1, psc_pkg::IDX_OFFSET, 8'hff);
    repeat (300) @(posedge clk);
    r = rise_at;
    chk("offset shift", {24'h0, 8'd255}, {24'h0, 8'(r[3] - r_ref)});
  endtask

  task automatic t_limit();
    @(posedge clk);
    ch_duty <= {8'h40, 8'h40, 8'h40, 8'h80, 8'hff, 8'h00};
    apb(1'b1, psc_pkg::IDX_PULSE_LIMIT, 8'hff);
    rdchk("pulse_limit", psc_pkg::IDX_PULSE_LIMIT, 8'h07);
    measure();
    chk_hi({{3{9'd64}}, 9'd128, 9'(256 - 2 * (7 + 1)), 9'(2 * (7 + 1))});
    apb(1'b1, psc_pkg::IDX_PULSE_LIMIT, 8'h00);
    measure();
    chk_hi({{3{9'd64}}, 9'd128, 9'(256 - 2 * (0 + 1)), 9'(2 * (0 + 1))});
  endtask

  task automatic t_masks();
    apb(1'b1, psc_pkg::IDX_RAMP, 8'hff);
    rdchk("soft_ramp_period", psc_pkg::IDX_RAMP, 8'h9f);
    chk("single ended", 32'h1, {31'h0, stage_se});
    apb(1'b1, psc_pkg::IDX_RAMP, 8'h00);
    rdchk("soft_ramp_period", psc_pkg::IDX_RAMP, 8'h00);
    chk("bridge tied", 32'h0, {31'h0, stage_se});
    apb(1'b1, psc_pkg::IDX_OFF_GROUP, 8'hff);
    rdchk("channel_off_group", psc_pkg::IDX_OFF_GROUP, 8'h3f);
    rdchk("group ignored", psc_pkg::IDX_STATUS, 8'h3f);
    apb(1'b1, psc_pkg::IDX_OFF_GROUP, 8'h05);
    apb(1'b1, psc_pkg::IDX_SYS_CTRL, 8'h00);
    rdchk("group 1 and 3 off", psc_pkg::IDX_STATUS, 8'h3a);
    apb(1'b1, 6'h11, 8'hff);
    rdchk("chan1_edge_delay", 6'h11, 8'hfc);
    apb(1'b1, 6'h18, 8'h5a);
    chk("unmapped error", 32'h1, {31'h0, er});
    rdchk("unmapped data", 6'h18, 8'h00);
  endtask

  // stopping channels also pass through the 50% period before going off
  task automatic t_soft_stop();
    apb(1'b1, psc_pkg::IDX_OFF_GROUP, 8'h00);
    rdchk("group cleared", psc_pkg::IDX_STATUS, 8'h3f);
    apb(1'b1, psc_pkg::IDX_RAMP, 8'h0a);
    apb(1'b1, psc_pkg::IDX_SYS_CTRL, 8'h40);
    rdchk("stop ramp busy", psc_pkg::IDX_STATUS, 8'h80);
    measure();
    chk_hi({6{9'd128}});
    repeat (80) @(posedge clk);
    rdchk("all stopped", psc_pkg::IDX_STATUS, 8'h00);
  endtask

  // watchdog: the whole run needs well under 10000 clocks
  initial begin
    #2_000_000;
    n_errors++;
    final_report();
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ch_duty = {6{8'h40}};
    meas = 1'b0;
    n_errors = 0;
    checks_done = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset_values();
    t_group_start();
    t_shutdown();
    t_soft_ramp();
    t_edges();
    t_limit();
    t_masks();
    t_soft_stop();
    final_report();
  end
endmodule // pwm_output_stage_config_tb
